//--- hdl/tws_pkg.sv
// tws_pkg: constants for the two-wire slave port
// assumes: one system clock domain plus one link-side sampling domain
package tws_pkg;
	// port mode field codes
	localparam logic [3:0] MODE_SLV7       = 4'h6;
	localparam logic [3:0] MODE_SLV10      = 4'h7;
	localparam logic [3:0] MODE_FW_MASTER  = 4'hB;
	localparam logic [3:0] MODE_SLV7_SP    = 4'hE;
	localparam logic [3:0] MODE_SLV10_SP   = 4'hF;
	// first byte of a ten-bit address carries this prefix
	localparam logic [4:0] TEN_BIT_PREFIX  = 5'h1E;
	// bits per byte and reset values
	localparam logic [3:0] BITS_PER_BYTE   = 4'h8;
	localparam logic [7:0] BYTE_RESET      = 8'h00;
	localparam logic [2:0] SYNC_RESET      = 3'h7;
endpackage

//--- hdl/tws_slave.sv
// tws_slave: two-wire bus slave with start/stop detection
// assumes: external pull-ups; pins arrive async to link_clk; software on clk
`timescale 1ns/1ps
`default_nettype none
module tws_slave
	import tws_pkg::*;
(
	// system side
	input  wire logic       clk,
	input  wire logic       rst_n,
	// link side sampling clock
	input  wire logic       link_clk,
	// control bits
	input  wire logic       port_enable,
	input  wire logic [3:0] port_mode_field,
	input  wire logic       clock_release_bit,
	input  wire logic [1:0] pin_direction_bits,   // [1] data, [0] clock; 1 = input
	input  wire logic [7:0] slave_address_register,
	input  wire logic       addr_write,          // pulse: address register rewritten
	input  wire logic       buf_read,            // pulse: receive buffer read
	input  wire logic       buf_write,           // pulse: transmit byte written
	input  wire logic [7:0] buf_wdata,
	input  wire logic       overflow_clear,      // pulse: software clears overflow
	input  wire logic       intr_clear,          // pulse: software clears interrupt
	// pins, as input / output / output enable (low = driving)
	input  wire logic       scl_in,
	output logic            scl_out,
	output logic            scl_oe_n,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_n,
	// status
	output logic [7:0]      rx_tx_buffer,
	output logic            buffer_full_flag,
	output logic            receive_overflow_flag,
	output logic            port_interrupt_flag,
	output logic            update_address_flag,
	output logic            rw_flag,
	output logic            data_addr_flag,
	output logic            start_flag,
	output logic            stop_flag,
	output logic            clock_stretch
);
	// ==========================================================
	// link domain: pin sampling and bus events
	// ==========================================================
	logic [2:0] scl_sync_reg;
	logic [2:0] sda_sync_reg;
	logic       scl_reg;
	logic       sda_reg;
	logic       lrst_meta_reg;
	logic       lrst_n_reg;

	// reset for the link side, resynchronised; rst_n and port_enable enter the link_clk flops directly as a level
	always_ff @(posedge link_clk) begin
		lrst_meta_reg <= rst_n & port_enable;
		lrst_n_reg    <= lrst_meta_reg;
	end

	// three-stage samplers; a change counts when the last two agree
	always_ff @(posedge link_clk) begin
		if (!lrst_n_reg) begin
			scl_sync_reg <= SYNC_RESET;
			sda_sync_reg <= SYNC_RESET;
			scl_reg      <= 1'b1;
			sda_reg      <= 1'b1;
		end else begin
			scl_sync_reg <= {scl_sync_reg[1:0], scl_in};
			sda_sync_reg <= {sda_sync_reg[1:0], sda_in};
			if (scl_sync_reg[1] == scl_sync_reg[2])
				scl_reg <= scl_sync_reg[2];
			if (sda_sync_reg[1] == sda_sync_reg[2])
				sda_reg <= sda_sync_reg[2];
		end
	end

	logic scl_q;
	logic sda_q;
	always_ff @(posedge link_clk) begin
		scl_q <= scl_reg;
		sda_q <= sda_reg;
	end

	wire scl_rise  = scl_reg & ~scl_q;
	wire scl_fall  = ~scl_reg & scl_q;
	wire start_det = scl_reg & scl_q & sda_q & ~sda_reg;
	wire stop_det  = scl_reg & scl_q & ~sda_q & sda_reg;

	// ==========================================================
	// system domain: mode decode and handshakes
	// ==========================================================
	// mode decode
	wire mode_ten    = (port_mode_field == MODE_SLV10) || (port_mode_field == MODE_SLV10_SP);
	wire mode_slave  = (port_mode_field == MODE_SLV7) || (port_mode_field == MODE_SLV7_SP) || mode_ten;
	wire mode_sp_int = (port_mode_field == MODE_SLV7_SP) || (port_mode_field == MODE_SLV10_SP) ||
	                   (port_mode_field == MODE_FW_MASTER);
	// 1011 keeps the slave idle, only 0110, 0111, 1110 and 1111 keep slave active
	wire mode_i2c    = mode_slave || (port_mode_field == MODE_FW_MASTER);

	// link-domain byte engine; mode config reaches it through two flops, the slave address unsynchronised (quasi static)
	logic [1:0] cfg_slave_s;
	logic [1:0] cfg_ten_s;
	always_ff @(posedge link_clk) begin
		cfg_slave_s <= {cfg_slave_s[0], mode_slave & port_enable};
		cfg_ten_s   <= {cfg_ten_s[0], mode_ten};
	end

	// ==========================================================
	// link domain byte engine
	// ==========================================================
	typedef enum {ST_IDLE, ST_SHIFT, ST_ACK, ST_TX, ST_TXACK} tws_state_t;
	tws_state_t state_reg;
	logic [7:0] shift_reg;
	logic [3:0] bit_cnt_reg;
	logic       addressed_reg;   // address accepted, data bytes follow
	logic       tx_mode_reg;
	logic       ack_drive_reg;   // pulling data low for our acknowledge
	logic       tx_bit_reg;
	logic       first10_reg;     // ten-bit high byte seen
	logic       ev_tog_reg;      // byte event toggle to clk
	logic       ev_load_reg;     // whether the event copies the byte
	logic       ev_addr_reg;     // event was an address byte
	logic       ev_rw_reg;
	logic       ev_ua_reg;
	logic       ev_nack_reg;     // master nack: reset status
	logic [7:0] ev_byte_reg;
	logic       st_tog_reg;
	logic       sp_tog_reg;
	logic [1:0] blk_s;           // buffer-full or overflow seen from clk
	logic [1:0] hold_s;          // clock stretch seen from clk
	logic [1:0] txtog_s;
	logic       txtog_q;
	logic [7:0] tx_data_hold;    // stable while tx toggle settles
	logic       ev_blocked_reg;
	logic       tx_req_tog_reg;  // transmit load toggle from clk, read here through txtog_s

	wire blocked   = blk_s[1];
	// seven- and ten-bit match, general call answered only in seven-bit mode when the address register bits [7:1] are zero
	wire addr7_hit = (shift_reg[7:1] == slave_address_register[7:1]);
	wire ten_hi    = (shift_reg[7:3] == TEN_BIT_PREFIX) && !shift_reg[0] &&
	                 (shift_reg[2:1] == slave_address_register[2:1]);
	wire ten_hi_rd = (shift_reg[7:3] == TEN_BIT_PREFIX) && shift_reg[0] && first10_reg &&
	                 (shift_reg[2:1] == slave_address_register[2:1]);
	wire ten_lo    = first10_reg && (shift_reg == slave_address_register);
	wire tx_load   = txtog_s[1] ^ txtog_q;

	always_ff @(posedge link_clk) begin
		blk_s   <= {blk_s[0], buffer_full_flag | receive_overflow_flag};
		hold_s  <= {hold_s[0], clock_stretch};
		txtog_s <= {txtog_s[0], tx_req_tog_reg};
		txtog_q <= txtog_s[1];
	end

	always_ff @(posedge link_clk) begin
		if (!lrst_n_reg || !cfg_slave_s[1]) begin
			state_reg     <= ST_IDLE;
			shift_reg     <= BYTE_RESET;
			bit_cnt_reg   <= 4'h0;
			addressed_reg <= 1'b0;
			tx_mode_reg   <= 1'b0;
			ack_drive_reg <= 1'b0;
			tx_bit_reg    <= 1'b1;
			first10_reg   <= 1'b0;
			ev_tog_reg    <= 1'b0;
			ev_load_reg   <= 1'b0;
			ev_addr_reg   <= 1'b0;
			ev_rw_reg     <= 1'b0;
			ev_ua_reg     <= 1'b0;
			ev_nack_reg   <= 1'b0;
			ev_byte_reg   <= BYTE_RESET;
			ev_blocked_reg <= 1'b0;
		end else if (start_det) begin
			state_reg     <= ST_SHIFT;
			bit_cnt_reg   <= 4'h0;
			addressed_reg <= 1'b0;
			tx_mode_reg   <= 1'b0;
			ack_drive_reg <= 1'b0;
			tx_bit_reg    <= 1'b1;
		end else if (stop_det) begin
			state_reg     <= ST_IDLE;
			ack_drive_reg <= 1'b0;
			tx_bit_reg    <= 1'b1;
			first10_reg   <= 1'b0;
		end else begin
			if (tx_load) begin
				shift_reg   <= tx_data_hold;
				bit_cnt_reg <= 4'h0;
				// a bit presented before the load must not block the first real bit
				tx_bit_reg  <= 1'b1;
			end
			case (state_reg)
				ST_SHIFT: begin
					if (scl_rise && bit_cnt_reg < BITS_PER_BYTE) begin
						shift_reg   <= {shift_reg[6:0], sda_reg};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
					end else if (scl_fall && bit_cnt_reg == BITS_PER_BYTE) begin
						state_reg   <= ST_ACK;
						ev_byte_reg <= shift_reg;
						ev_nack_reg <= 1'b0;
						ev_blocked_reg <= blocked;
						ev_ua_reg   <= 1'b0;
						ev_rw_reg   <= shift_reg[0];
						if (addressed_reg) begin
							ev_addr_reg   <= 1'b0;
							ev_load_reg   <= !blocked;
							ack_drive_reg <= !blocked;
						end else if (cfg_ten_s[1]) begin
							ev_addr_reg <= 1'b1;
							if (ten_hi_rd) begin
								ev_load_reg   <= !blocked;
								ack_drive_reg <= !blocked;
								addressed_reg <= 1'b1;
								tx_mode_reg   <= 1'b1;
							end else if (ten_hi || ten_lo) begin
								ev_load_reg   <= !blocked;
								ack_drive_reg <= !blocked;
								ev_ua_reg     <= 1'b1;
								first10_reg   <= ten_hi | first10_reg;
								addressed_reg <= ten_lo;
							end else begin
								ev_load_reg <= 1'b0;
								state_reg   <= ST_IDLE;
								ev_tog_reg  <= ev_tog_reg;
							end
						end else begin
							ev_addr_reg <= 1'b1;
							if (addr7_hit) begin
								ev_load_reg   <= !blocked;
								ack_drive_reg <= !blocked;
								addressed_reg <= 1'b1;
								tx_mode_reg   <= shift_reg[0];
							end else begin
								ev_load_reg <= 1'b0;
								state_reg   <= ST_IDLE;
								ev_tog_reg  <= ev_tog_reg;
							end
						end
					end
				end
				ST_ACK: begin
					// acknowledge occupies the ninth clock; leave it on the ninth fall
					if (scl_fall) begin
						// byte event on the ninth fall, so a stretch never cuts the ack pulse
						ev_tog_reg    <= ~ev_tog_reg;
						ack_drive_reg <= 1'b0;
						bit_cnt_reg   <= 4'h0;
						state_reg     <= tx_mode_reg ? ST_TX : ST_SHIFT;
						if (tx_mode_reg)
							tx_bit_reg <= 1'b1;
					end
				end
				ST_TX: begin
					// present next bit after each fall while clock is released
					if (!hold_s[1] && bit_cnt_reg == 4'h0 && !scl_reg && tx_bit_reg && !tx_load) begin
						tx_bit_reg  <= shift_reg[7];
						shift_reg   <= {shift_reg[6:0], 1'b1};
						bit_cnt_reg <= 4'h1;
					end else if (scl_fall && bit_cnt_reg != 4'h0) begin
						if (bit_cnt_reg == BITS_PER_BYTE) begin
							tx_bit_reg <= 1'b1;
							state_reg  <= ST_TXACK;
						end else begin
							tx_bit_reg  <= shift_reg[7];
							shift_reg   <= {shift_reg[6:0], 1'b1};
							bit_cnt_reg <= bit_cnt_reg + 4'h1;
						end
					end
				end
				ST_TXACK: begin
					// master acknowledge latched on ninth rise
					if (scl_rise) begin
						ev_tog_reg  <= ~ev_tog_reg;
						ev_load_reg <= 1'b0;
						ev_addr_reg <= 1'b0;
						ev_ua_reg   <= 1'b0;
						ev_blocked_reg <= 1'b0;
						ev_nack_reg <= sda_reg;
						ev_rw_reg   <= 1'b1;
						state_reg   <= sda_reg ? ST_IDLE : ST_TX;
						bit_cnt_reg <= 4'h0;
						addressed_reg <= !sda_reg;
					end
				end
				default: ;
			endcase
		end
	end

	// start/stop event toggles
	always_ff @(posedge link_clk) begin
		if (!lrst_n_reg) begin
			st_tog_reg <= 1'b0;
			sp_tog_reg <= 1'b0;
		end else begin
			if (start_det)
				st_tog_reg <= ~st_tog_reg;
			if (stop_det)
				sp_tog_reg <= ~sp_tog_reg;
		end
	end

	// ==========================================================
	// system domain: event crossing and status
	// ==========================================================
	logic [2:0] ev_s;
	logic [2:0] st_s;
	logic [2:0] sp_s;
	always_ff @(posedge clk) begin
		ev_s <= {ev_s[1:0], ev_tog_reg};
		st_s <= {st_s[1:0], st_tog_reg};
		sp_s <= {sp_s[1:0], sp_tog_reg};
	end
	wire byte_ev  = ev_s[2] ^ ev_s[1];
	wire start_ev = st_s[2] ^ st_s[1];
	wire stop_ev  = sp_s[2] ^ sp_s[1];
	wire on       = port_enable & mode_i2c;
	// received-byte fields are stable for many clk cycles before the toggle is seen; master-ack fields change with it
	wire rx_ev    = byte_ev & !ev_nack_reg & (ev_addr_reg | !tx_mode_reg | ev_ua_reg);

	// buffer and buffer full (set beats clear)
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_tx_buffer     <= BYTE_RESET;
			buffer_full_flag <= 1'b0;
		end else if (!port_enable) begin
			buffer_full_flag <= 1'b0;
		end else begin
			if (buf_write)
				rx_tx_buffer <= buf_wdata;
			else if (byte_ev && ev_load_reg)
				rx_tx_buffer <= ev_byte_reg;
			if (byte_ev && ev_load_reg)
				buffer_full_flag <= 1'b1;
			else if (buf_read)
				buffer_full_flag <= 1'b0;
		end
	end

	// overflow set on a blocked received byte, software clears it
	always_ff @(posedge clk) begin
		if (!rst_n)
			receive_overflow_flag <= 1'b0;
		else if (byte_ev && rx_ev && ev_blocked_reg && !ev_load_reg && buffer_full_flag)
			receive_overflow_flag <= 1'b1;
		else if (overflow_clear)
			receive_overflow_flag <= 1'b0;
	end

	// interrupt flag on bytes and, in master-support modes, start/stop
	always_ff @(posedge clk) begin
		if (!rst_n)
			port_interrupt_flag <= 1'b0;
		else if (on && (byte_ev || (mode_sp_int && (start_ev || stop_ev))))
			port_interrupt_flag <= 1'b1;
		else if (intr_clear)
			port_interrupt_flag <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rw_flag        <= 1'b0;
			data_addr_flag <= 1'b0;
		end else if (byte_ev && ev_nack_reg) begin
			rw_flag        <= 1'b0;
			data_addr_flag <= 1'b0;
		end else if (byte_ev) begin
			if (ev_addr_reg)
				rw_flag <= ev_rw_reg;
			data_addr_flag <= !ev_addr_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || !port_enable) begin
			start_flag <= 1'b0;
			stop_flag  <= 1'b0;
		end else if (start_ev) begin
			start_flag <= 1'b1;
			stop_flag  <= 1'b0;
		end else if (stop_ev) begin
			start_flag <= 1'b0;
			stop_flag  <= 1'b1;
		end
	end

	// update flag and clock stretch; event set wins over release
	always_ff @(posedge clk) begin
		if (!rst_n || !port_enable) begin
			update_address_flag <= 1'b0;
			clock_stretch       <= 1'b0;
		end else begin
			if (byte_ev && ev_ua_reg)
				update_address_flag <= 1'b1;
			else if (addr_write)
				update_address_flag <= 1'b0;
			if (byte_ev && (ev_ua_reg || (ev_rw_reg && !ev_nack_reg && (tx_mode_reg || ev_addr_reg))))
				clock_stretch <= 1'b1;
			else if ((update_address_flag && addr_write) || (!update_address_flag && clock_release_bit))
				clock_stretch <= 1'b0;
		end
	end

	// transmit byte also fills the shift register through a toggle
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_req_tog_reg <= 1'b0;
			tx_data_hold   <= BYTE_RESET;
		end else if (buf_write) begin
			tx_req_tog_reg <= ~tx_req_tog_reg;
			tx_data_hold   <= buf_wdata;
		end
	end

	// ==========================================================
	// pin drivers
	// ==========================================================
	logic [1:0] ack_s;
	logic [1:0] txb_s;
	always_ff @(posedge clk) begin
		ack_s <= {ack_s[0], ack_drive_reg};
		txb_s <= {txb_s[0], tx_bit_reg};
	end

	// open drain: low only; enable low while pulling
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			scl_out  <= 1'b0;
			sda_out  <= 1'b0;
			scl_oe_n <= 1'b1;
			sda_oe_n <= 1'b1;
		end else begin
			scl_out  <= 1'b0;
			sda_out  <= 1'b0;
			scl_oe_n <= !(!pin_direction_bits[0] || (on && mode_slave && clock_stretch));
			sda_oe_n <= !(!pin_direction_bits[1] || (on && mode_slave && (ack_s[1] || !txb_s[1])));
		end
	end

	// ==========================================================
	// checks
	// ==========================================================
	a_start_clears_stop: assert property (@(posedge clk) disable iff (!rst_n)
		(start_ev && port_enable) |=> (start_flag && !stop_flag))
		else $error("start did not set start flag");
	a_disable_clears: assert property (@(posedge clk) disable iff (!rst_n)
		!port_enable |=> (!start_flag && !stop_flag && !buffer_full_flag))
		else $error("disable left flags set");
	a_read_clears_full: assert property (@(posedge clk) disable iff (!rst_n)
		(buf_read && !byte_ev && port_enable) |=> !buffer_full_flag)
		else $error("buffer read kept full flag");
	a_load_sets_full: assert property (@(posedge clk) disable iff (!rst_n)
		(byte_ev && ev_load_reg && port_enable) |=> (buffer_full_flag && rx_tx_buffer == $past(ev_byte_reg)))
		else $error("byte not loaded");
	a_byte_sets_intr: assert property (@(posedge clk) disable iff (!rst_n)
		(byte_ev && on) |=> port_interrupt_flag)
		else $error("byte missed interrupt");
	a_ua_holds_clock: assert property (@(posedge clk) disable iff (!rst_n)
		(byte_ev && ev_ua_reg && port_enable) |=> (update_address_flag && clock_stretch))
		else $error("update address did not stretch");
	a_dir_low_drives: assert property (@(posedge clk) disable iff (!rst_n)
		!pin_direction_bits[0] |=> (!scl_oe_n && !scl_out))
		else $error("clock not pulled low");
	a_overflow_sticky: assert property (@(posedge clk) disable iff (!rst_n)
		(receive_overflow_flag && !overflow_clear) |=> receive_overflow_flag)
		else $error("overflow cleared without write");
endmodule
`default_nettype wire

//--- test/tws_master_model.sv
// tws_master_model: behavioural two-wire bus master for the slave bench
// assumes: the bench resolves both open-drain lines with pull-ups
`timescale 1ns/1ps
`default_nettype none
module tws_master_model (
	// clock and resolved lines
	input  wire logic clk,
	input  wire logic scl,
	input  wire logic sda,
	// pull-low requests
	output logic      scl_low,
	output logic      sda_low
);
	localparam int HALF = 20;

	// lines released until the first transfer
	initial begin
		scl_low = 1'b0;
		sda_low = 1'b0;
	end

	// ==========
	// bit level
	task automatic half();
		repeat (HALF) @(posedge clk);
	endtask

	// clock line checked before each pulse
	task automatic rise();
		int n;
		n = 0;
		half();
		scl_low <= 1'b0;
		@(posedge clk);
		// bounded, so a slave that never lets go cannot hang us
		while (!scl && n < 4000) begin
			@(posedge clk);
			n++;
		end
		half();
	endtask

	// sample near the end of the high time, then pull clock low
	task automatic pulse(output logic s);
		rise();
		s = sda;
		scl_low <= 1'b1;
	endtask

	// ==========
	// frame level
	task automatic start();
		sda_low <= 1'b0;
		rise();
		sda_low <= 1'b1;
		half();
		scl_low <= 1'b1;
	endtask

	task automatic stop();
		sda_low <= 1'b1;
		rise();
		sda_low <= 1'b0;
		half();
	endtask

	// msb first, ninth pulse reads the acknowledge
	task automatic write_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			sda_low <= ~b[i];
			pulse(s);
		end
		sda_low <= 1'b0;
		pulse(ack);
	endtask

	task automatic read_byte(input logic nak, output logic [7:0] b);
		logic s;
		sda_low <= 1'b0;
		for (int i = 7; i >= 0; i--) begin
			pulse(s);
			b[i] = s;
		end
		sda_low <= ~nak;
		pulse(s);
		sda_low <= 1'b0;
	endtask
endmodule
`default_nettype wire

//--- test/tws_slave_tb.sv
// tws_slave_tb: self-checking bench for the two-wire slave
// assumes: pull-ups on both lines, master model on the far side
`timescale 1ns/1ps
`default_nettype none
module tws_slave_tb;
	import tws_pkg::*;
	localparam logic [4:0] AW = 5'h01, BR = 5'h02, BW = 5'h04, OC = 5'h08, IC = 5'h10;
	logic       clk, rst_n, link_clk, port_enable, clock_release_bit, scl, sda;
	logic [3:0] port_mode_field;
	logic [1:0] pin_direction_bits;
	logic [7:0] slave_address_register, buf_wdata, rx_tx_buffer, st;
	logic [4:0] pul;
	logic       scl_out, scl_oe_n, sda_out, sda_oe_n, scl_low, sda_low, clock_stretch;
	logic       buffer_full_flag, receive_overflow_flag, port_interrupt_flag, update_address_flag;
	logic       rw_flag, data_addr_flag, start_flag, stop_flag;
	int         num_errors, tests_run, cycles = 0;

	tws_slave dut (
		.clk(clk), .rst_n(rst_n), .link_clk(link_clk), .port_enable(port_enable),
		.port_mode_field(port_mode_field), .clock_release_bit(clock_release_bit),
		.pin_direction_bits(pin_direction_bits), .slave_address_register(slave_address_register),
		.addr_write(pul[0]), .buf_read(pul[1]), .buf_write(pul[2]), .buf_wdata(buf_wdata),
		.overflow_clear(pul[3]), .intr_clear(pul[4]),
		.scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
		.sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
		.rx_tx_buffer(rx_tx_buffer), .buffer_full_flag(buffer_full_flag),
		.receive_overflow_flag(receive_overflow_flag), .port_interrupt_flag(port_interrupt_flag),
		.update_address_flag(update_address_flag), .rw_flag(rw_flag), .data_addr_flag(data_addr_flag),
		.start_flag(start_flag), .stop_flag(stop_flag), .clock_stretch(clock_stretch)
	);
	tws_master_model bfm (.clk(clk), .scl(scl), .sda(sda), .scl_low(scl_low), .sda_low(sda_low));

	// ==========
	// clocks, lines and status
	always #50 clk = ~clk;
	// link clock phase offset so edges never line up with clk
	initial begin
		link_clk = 1'b0;
		#7;
		forever #16 link_clk = ~link_clk;
	end
	// open-drain lines with pull-ups
	assign scl = ~scl_low & (scl_oe_n | scl_out);
	assign sda = ~sda_low & (sda_oe_n | sda_out);
	// status packed: full ovf intr upd rw data start stop
	assign st = {buffer_full_flag, receive_overflow_flag, port_interrupt_flag, update_address_flag,
		rw_flag, data_addr_flag, start_flag, stop_flag};

	// ==========
	// helpers
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		tests_run++;
		if (g !== e) begin
			$display("mismatch %s expected %h seen %h", nm, e, g);
			num_errors++;
		end
	endtask

	task automatic sw(input logic [4:0] m);
		@(posedge clk) pul <= m;
		@(posedge clk) pul <= 5'h00;
		repeat (6) @(posedge clk);
	endtask

	task automatic settle();
		repeat (12) @(posedge clk);
	endtask

	// k selects clock stretch, else update flag
	task automatic wait_on(input logic k);
		int n;
		n = 0;
		while ((k ? clock_stretch : update_address_flag) !== 1'b1 && n < 5000) begin
			@(posedge clk);
			n++;
		end
		if (n == 5000) begin
			$display("mismatch wait %0d expected 1 seen 0", k);
			num_errors++;
		end
		@(posedge clk);
	endtask

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ==========
	// scenarios
	task automatic t_write7();
		logic a;
		bfm.start();
		bfm.write_byte(8'hA0, a);
		settle();
		chk("addr ack", 8'h00, {7'h0, a});
		chk("addr buf", 8'hA0, rx_tx_buffer);
		chk("addr st", 8'hA2, st);
		sw(IC);
		bfm.write_byte(8'h3C, a);
		settle();
		chk("full ack", 8'h01, {7'h0, a});
		chk("full buf", 8'hA0, rx_tx_buffer);
		chk("full st", 8'hE0, st & 8'hE0);
		sw(BR | OC | IC);
		chk("clr st", 8'h00, st & 8'hE0);
		bfm.write_byte(8'h5A, a);
		settle();
		chk("data ack", 8'h00, {7'h0, a});
		chk("data buf", 8'h5A, rx_tx_buffer);
		chk("data st", 8'hA6, st);
		sw(BR | IC);
		bfm.stop();
		settle();
		chk("stop st", 8'h01, st & 8'h23);
		// wrong address is ignored
		bfm.start();
		bfm.write_byte(8'hB0, a);
		settle();
		chk("miss ack", 8'h01, {7'h0, a});
		chk("miss st", 8'h00, st & 8'hA0);
		bfm.stop();
	endtask

	task automatic t_read7();
		logic       a;
		logic [7:0] b;
		clock_release_bit <= 1'b0;
		bfm.start();
		bfm.write_byte(8'hA1, a);
		settle();
		chk("rd ack", 8'h00, {7'h0, a});
		chk("rd st", 8'hAA, st);
		fork
			bfm.read_byte(1'b1, b);
			begin
				wait_on(1'b1);
				chk("stretch", 8'h01, {5'h0, scl, scl_oe_n, clock_stretch});
				buf_wdata <= 8'hA5;
				// software loads byte and lets the clock go
				sw(BW | BR | IC);
				clock_release_bit <= 1'b1;
			end
		join
		settle();
		chk("rd data", 8'hA5, b);
		chk("nak st", 8'h00, st & 8'h0C);
		bfm.stop();
	endtask

	task automatic t_ten();
		logic a1, a2;
		port_mode_field <= MODE_SLV10;
		slave_address_register <= 8'hF2;
		settle();
		fork
			begin
				bfm.start();
				// first address byte sent as a write
				bfm.write_byte(8'hF2, a1);
				bfm.write_byte(8'h34, a2);
				bfm.stop();
			end
			begin
				wait_on(1'b0);
				chk("hi buf", 8'hF2, rx_tx_buffer);
				chk("hi hold", 8'h00, {7'h0, scl_oe_n});
				// software rewrites the address with the other byte
				slave_address_register <= 8'h34;
				sw(AW | BR | IC);
				chk("upd clr", 8'h00, {7'h0, update_address_flag});
				wait_on(1'b0);
				chk("lo buf", 8'h34, rx_tx_buffer);
				slave_address_register <= 8'hF2;
				sw(AW | BR | IC);
			end
		join
		chk("ten ack", 8'h00, {6'h0, a1, a2});
	endtask

	// firmware master with slave idle or active
	task automatic t_fwm();
		logic [3:0] modes [3] = '{MODE_SLV7_SP, MODE_SLV10_SP, MODE_FW_MASTER};
		foreach (modes[i]) begin
			port_mode_field <= modes[i];
			sw(IC);
			pin_direction_bits <= 2'b01;
			settle();
			chk("fw start", 8'h22, st & 8'h23);
			chk("fw oe", 8'h02, {4'h0, scl_out, sda_out, scl_oe_n, sda_oe_n});
			sw(IC);
			pin_direction_bits <= 2'b00;
			settle();
			chk("fw low", 8'h00, {6'h0, scl, sda});
			pin_direction_bits <= 2'b01;
			settle();
			pin_direction_bits <= 2'b11;
			settle();
			// stop seen, bus free for firmware
			chk("fw stop", 8'h21, st & 8'h23);
		end
		port_enable <= 1'b0;
		settle();
		chk("off st", 8'h00, st & 8'h03);
	endtask

	// ==========
	// main sequence
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		port_enable = 1'b1;
		port_mode_field = MODE_SLV7;
		clock_release_bit = 1'b1;
		pin_direction_bits = 2'b11;
		slave_address_register = 8'hA0;
		buf_wdata = 8'h00;
		pul = 5'h00;
		num_errors = 0;
		tests_run = 0;
		repeat (12) @(posedge clk);
		chk("rst st", 8'h00, st);
		chk("rst oe", 8'h03, {6'h0, scl_oe_n, sda_oe_n});
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		t_write7();
		t_read7();
		t_ten();
		t_fwm();
		tally_and_finish();
	end

	// cycle ceiling cuts a hung bus short
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 30000) begin
			num_errors++;
			tally_and_finish();
		end
	end
endmodule
`default_nettype wire
